// ---- verilog/csb_pkg.sv ----
// shared constants, operations and carriers of the compare, skip and branch unit
package csb_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int PC_W = 16;
    localparam int FLAG_W = 8;

    // byte addresses of the register words
    localparam logic [ADDR_W-1:0] OFS_OPERAND = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PC = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;

    // condition flag register bit positions
    localparam int FLG_BORROW = 0;
    localparam int FLG_NULL = 1;
    localparam int FLG_MSB = 2;
    localparam int FLG_WRAP = 3;
    localparam int FLG_NIBBLE = 5;

    // field positions of the command and status words, and the operand word width
    localparam int CMD_OP_LSB = 0;
    localparam int OPERAND_W = 27;
    localparam int ST_REFUSED = 0;
    localparam int ST_BAD_OP = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_TAKEN = 3;
    localparam int ST_CYC_LSB = 4;

    localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] SKIP_SHORT = 16'h0002;
    localparam logic [PC_W-1:0] SKIP_LONG = 16'h0003;

    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [3:0] {
        OP_COMPARE_WITH_CONSTANT,
        OP_SKIP_IF_REG_BIT_CLEAR,
        OP_SKIP_IF_REG_BIT_SET,
        OP_SKIP_IF_IO_BIT_CLEAR,
        OP_SKIP_IF_IO_BIT_SET,
        OP_BRANCH_IF_FLAG_SET,
        OP_BRANCH_IF_FLAG_CLEAR,
        OP_BRANCH_IF_EQUAL,
        OP_BRANCH_IF_NOT_EQUAL,
        OP_BRANCH_IF_CARRY_SET,
        OP_BRANCH_IF_CARRY_CLEAR,
        OP_BRANCH_IF_SAME_OR_HIGHER
    } csb_op_t;

    // operand word, low bit first: reg_val, imm_io, offset, bit_sel, two_word
    typedef struct packed {
        logic two_word;
        logic [2:0] bit_sel;
        logic [6:0] offset;
        logic [7:0] imm_io;
        logic [7:0] reg_val;
    } csb_operand_t;

endpackage : csb_pkg

// ---- verilog/csb_unit.sv ----
// compare, bit-test skip and relative branch execution unit with an apb register port
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////////
module csb_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csb_pkg::ADDR_W-1:0] paddr,
    input wire logic [csb_pkg::DATA_W-1:0] pwdata,
    output logic [csb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [csb_pkg::PC_W-1:0] pc,
    output logic [csb_pkg::FLAG_W-1:0] flags,
    output logic busy
);

    //////////////////////////////////////////////////////////////////////////////////////////////
    // state

    logic [csb_pkg::DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    csb_pkg::csb_operand_t opnd_ff;
    logic [csb_pkg::PC_W-1:0] pc_ff;
    logic [csb_pkg::FLAG_W-1:0] flags_ff;
    logic busy_ff;
    logic [1:0] cnt_ff;
    logic taken_ff;
    logic [1:0] last_cyc_ff;
    logic refused_ff;
    logic bad_op_ff;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // apb decode

    function automatic logic csb_is(input logic [csb_pkg::ADDR_W-1:0] a, input logic [csb_pkg::ADDR_W-1:0] ofs);
        csb_is = (a == ofs);
    endfunction : csb_is

    wire setup_ph = psel & ~penable;
    wire access_wr = psel & penable & pready_ff & pwrite;
    wire hit_operand = csb_is(paddr, csb_pkg::OFS_OPERAND);
    wire hit_command = csb_is(paddr, csb_pkg::OFS_COMMAND);
    wire hit_flags = csb_is(paddr, csb_pkg::OFS_FLAGS);
    wire hit_pc = csb_is(paddr, csb_pkg::OFS_PC);
    wire hit_status = csb_is(paddr, csb_pkg::OFS_STATUS);
    wire mapped = hit_operand | hit_command | hit_flags | hit_pc | hit_status;
    wire wr_operand = access_wr & hit_operand;
    wire wr_command = access_wr & hit_command;
    wire wr_flags = access_wr & hit_flags;
    wire wr_pc = access_wr & hit_pc;
    wire wr_status = access_wr & hit_status;

    wire [csb_pkg::DATA_W-1:0] status_word = {26'h000_0000, last_cyc_ff, taken_ff, busy_ff, bad_op_ff, refused_ff};
    wire [csb_pkg::DATA_W-1:0] rd_mux =
        hit_operand ? {5'h00, opnd_ff} :
        hit_flags ? {24'h00_0000, flags_ff} :
        hit_pc ? {16'h0000, pc_ff} :
        hit_status ? status_word : {csb_pkg::DATA_W{1'b0}};

    //////////////////////////////////////////////////////////////////////////////////////////////
    // instruction issue

    wire [3:0] op_raw = pwdata[csb_pkg::CMD_OP_LSB +: 4];
    wire op_legal = (op_raw <= 4'(csb_pkg::OP_BRANCH_IF_SAME_OR_HIGHER));
    wire csb_pkg::csb_op_t op = csb_pkg::csb_op_t'(op_raw);
    // a command written while the previous one still runs is dropped, not queued
    wire issue = wr_command & ~busy_ff & op_legal;
    wire refuse = wr_command & busy_ff;
    wire bad_op = wr_command & ~busy_ff & ~op_legal;

    // compare arithmetic, result itself is never stored
    wire [7:0] rd_v = opnd_ff.reg_val;
    wire [7:0] k_v = opnd_ff.imm_io;
    wire [7:0] diff = rd_v - k_v;
    wire f_borrow = (~rd_v[7] & k_v[7]) | (k_v[7] & diff[7]) | (diff[7] & ~rd_v[7]);
    wire f_nibble = (~rd_v[3] & k_v[3]) | (k_v[3] & diff[3]) | (diff[3] & ~rd_v[3]);
    wire f_wrap = (rd_v[7] & ~k_v[7] & ~diff[7]) | (~rd_v[7] & k_v[7] & diff[7]);
    wire f_null = (diff == 8'h00);

    logic [csb_pkg::FLAG_W-1:0] cmp_flags;
    always_comb
    begin
        cmp_flags = flags_ff;
        cmp_flags[csb_pkg::FLG_BORROW] = f_borrow;
        cmp_flags[csb_pkg::FLG_NULL] = f_null;
        cmp_flags[csb_pkg::FLG_MSB] = diff[7];
        cmp_flags[csb_pkg::FLG_WRAP] = f_wrap;
        cmp_flags[csb_pkg::FLG_NIBBLE] = f_nibble;
    end

    wire reg_bit = opnd_ff.reg_val[opnd_ff.bit_sel];
    wire io_bit = opnd_ff.imm_io[opnd_ff.bit_sel];
    wire sel_flag = flags_ff[opnd_ff.bit_sel];
    wire fz = flags_ff[csb_pkg::FLG_NULL];
    wire fc = flags_ff[csb_pkg::FLG_BORROW];

    logic cond;
    logic is_skip;
    always_comb
    begin
        cond = 1'b0;
        is_skip = 1'b0;
        unique case (op)
            csb_pkg::OP_COMPARE_WITH_CONSTANT: cond = 1'b0;
            csb_pkg::OP_SKIP_IF_REG_BIT_CLEAR:
            begin
                cond = ~reg_bit;
                is_skip = 1'b1;
            end
            csb_pkg::OP_SKIP_IF_REG_BIT_SET:
            begin
                cond = reg_bit;
                is_skip = 1'b1;
            end
            csb_pkg::OP_SKIP_IF_IO_BIT_CLEAR:
            begin
                cond = ~io_bit;
                is_skip = 1'b1;
            end
            csb_pkg::OP_SKIP_IF_IO_BIT_SET:
            begin
                cond = io_bit;
                is_skip = 1'b1;
            end
            csb_pkg::OP_BRANCH_IF_FLAG_SET: cond = sel_flag;
            csb_pkg::OP_BRANCH_IF_FLAG_CLEAR: cond = ~sel_flag;
            csb_pkg::OP_BRANCH_IF_EQUAL: cond = fz;
            csb_pkg::OP_BRANCH_IF_NOT_EQUAL: cond = ~fz;
            csb_pkg::OP_BRANCH_IF_CARRY_SET: cond = fc;
            csb_pkg::OP_BRANCH_IF_CARRY_CLEAR: cond = ~fc;
            csb_pkg::OP_BRANCH_IF_SAME_OR_HIGHER: cond = ~fc;
            default:
            begin
                cond = 1'b0;
                is_skip = 1'b0;
            end
        endcase
    end

    // signed word offset, sign-extended to the pc width
    wire [csb_pkg::PC_W-1:0] rel = {{(csb_pkg::PC_W-7){opnd_ff.offset[6]}}, opnd_ff.offset};
    wire [csb_pkg::PC_W-1:0] skip_step = opnd_ff.two_word ? csb_pkg::SKIP_LONG : csb_pkg::SKIP_SHORT;
    wire [csb_pkg::PC_W-1:0] pc_exec =
        ~cond ? pc_ff + csb_pkg::PC_STEP :
        is_skip ? pc_ff + skip_step :
        pc_ff + rel + csb_pkg::PC_STEP;
    // taken skip pays one cycle per discarded word, taken branch one for the dropped fetch
    wire [1:0] cyc_exec =
        ~cond ? csb_pkg::CYC_ONE :
        ~is_skip ? csb_pkg::CYC_TWO :
        opnd_ff.two_word ? csb_pkg::CYC_THREE : csb_pkg::CYC_TWO;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // next values

    wire [1:0] cnt_dec = cnt_ff - 2'h1;
    wire [1:0] nxt_cnt = issue ? cyc_exec - csb_pkg::CYC_ONE : (busy_ff ? cnt_dec : 2'h0);
    wire nxt_busy = (nxt_cnt != 2'h0);
    wire is_cmp = (op == csb_pkg::OP_COMPARE_WITH_CONSTANT);
    // only the compare touches flags; every skip and branch leaves them alone
    wire [csb_pkg::FLAG_W-1:0] nxt_flags =
        (issue & is_cmp) ? cmp_flags :
        wr_flags ? pwdata[csb_pkg::FLAG_W-1:0] : flags_ff;
    wire [csb_pkg::PC_W-1:0] nxt_pc = issue ? pc_exec : (wr_pc ? pwdata[csb_pkg::PC_W-1:0] : pc_ff);
    // hardware set beats the software clear
    wire nxt_refused = refuse | (refused_ff & ~(wr_status & pwdata[csb_pkg::ST_REFUSED]));
    wire nxt_bad_op = bad_op | (bad_op_ff & ~(wr_status & pwdata[csb_pkg::ST_BAD_OP]));

    //////////////////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= setup_ph ? rd_mux : prdata_ff;
            pready_ff <= setup_ph;
            pslverr_ff <= setup_ph & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opnd_ff <= '0;
            pc_ff <= csb_pkg::PC_RST;
            flags_ff <= csb_pkg::FLAGS_RST;
            busy_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end
        else
        begin
            opnd_ff <= wr_operand ? csb_pkg::csb_operand_t'(pwdata[csb_pkg::OPERAND_W-1:0]) : opnd_ff;
            pc_ff <= nxt_pc;
            flags_ff <= nxt_flags;
            busy_ff <= nxt_busy;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            taken_ff <= 1'b0;
            last_cyc_ff <= 2'h0;
            refused_ff <= 1'b0;
            bad_op_ff <= 1'b0;
        end
        else
        begin
            taken_ff <= issue ? cond : taken_ff;
            last_cyc_ff <= issue ? cyc_exec : last_cyc_ff;
            refused_ff <= nxt_refused;
            bad_op_ff <= nxt_bad_op;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pc = pc_ff;
    assign flags = flags_ff;
    assign busy = busy_ff;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // checks

    AST_CMP_NULL: assert property (@(posedge pclk) disable iff (!presetn)
        issue && is_cmp |=> flags_ff[csb_pkg::FLG_NULL] == ($past(opnd_ff.reg_val) == $past(opnd_ff.imm_io)))
        else $error("compare null flag wrong");

    AST_CMP_BORROW: assert property (@(posedge pclk) disable iff (!presetn)
        issue && is_cmp |=> flags_ff[csb_pkg::FLG_BORROW] == ($past(opnd_ff.reg_val) < $past(opnd_ff.imm_io))
            && !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("compare borrow, length or pc wrong");

    AST_SKIP_LONG: assert property (@(posedge pclk) disable iff (!presetn)
        issue && is_skip && cond && opnd_ff.two_word
            |=> pc_ff == 16'($past(pc_ff) + 16'h0003) ##0 busy_ff[*2] ##1 !busy_ff)
        else $error("two-word skip not three words and three cycles");

    AST_SKIP_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && is_skip && cond && !opnd_ff.two_word
            |=> pc_ff == 16'($past(pc_ff) + 16'h0002) ##0 busy_ff ##1 !busy_ff)
        else $error("one-word skip not two words and two cycles");

    AST_IO_SET: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_SKIP_IF_IO_BIT_SET && !opnd_ff.imm_io[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("io skip taken on clear bit");

    AST_FLAGS_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && !is_cmp |=> $stable(flags_ff))
        else $error("skip or branch changed flags");

    AST_BRANCH_TAKEN: assert property (@(posedge pclk) disable iff (!presetn)
        issue && !is_cmp && !is_skip && cond
            |=> pc_ff == 16'($past(pc_ff) + {{9{$past(opnd_ff.offset[6])}}, $past(opnd_ff.offset)} + 16'h0001)
            ##0 busy_ff ##1 !busy_ff)
        else $error("taken branch target or length wrong");

    AST_SAME_HIGHER: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_SAME_OR_HIGHER |-> cond == !flags_ff[csb_pkg::FLG_BORROW])
        else $error("same-or-higher condition differs from carry clear");

    AST_EQUAL: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_EQUAL && !flags_ff[csb_pkg::FLG_NULL]
            |=> pc_ff == 16'($past(pc_ff) + 16'h0001) && !busy_ff)
        else $error("equal branch taken with null flag clear");

    AST_REG_CLEAR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_SKIP_IF_REG_BIT_CLEAR && opnd_ff.reg_val[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("register clear skip taken on set bit");

    AST_REG_SET_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_SKIP_IF_REG_BIT_SET && !opnd_ff.reg_val[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("register set skip taken on clear bit");

    AST_IO_CLEAR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_SKIP_IF_IO_BIT_CLEAR && opnd_ff.imm_io[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("io clear skip taken on set bit");

    AST_FLAG_SET_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_FLAG_SET && !flags_ff[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("flag set branch taken on clear flag");

    AST_FLAG_CLEAR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_FLAG_CLEAR && flags_ff[opnd_ff.bit_sel]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("flag clear branch taken on set flag");

    AST_NOT_EQUAL_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_NOT_EQUAL && flags_ff[csb_pkg::FLG_NULL]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("not equal branch taken with null flag set");

    AST_CARRY_SET_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_CARRY_SET && !flags_ff[csb_pkg::FLG_BORROW]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("carry set branch taken with borrow clear");

    AST_CARRY_CLEAR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && op == csb_pkg::OP_BRANCH_IF_CARRY_CLEAR && flags_ff[csb_pkg::FLG_BORROW]
            |=> !busy_ff && pc_ff == 16'($past(pc_ff) + 16'h0001))
        else $error("carry clear branch taken with borrow set");

    AST_REFUSE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        refuse |=> refused_ff && $stable(pc_ff))
        else $error("command while busy not refused");

    AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready_ff |=> !pready_ff)
        else $error("pready held more than one cycle");

endmodule : csb_unit

// ---- verification/tb_csb_unit.sv ----
// self-checking testbench of the compare, skip and branch unit
`timescale 1ns/1ps

module tb_csb_unit;

    typedef struct packed {
        logic [3:0] op;
        logic [7:0] rv;
        logic [7:0] imm;
        logic [6:0] off;
        logic [2:0] bs;
        logic tw;
        logic [7:0] fl;
        logic [15:0] pc0;
        logic tk;
    } csb_row_t;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [csb_pkg::ADDR_W-1:0] paddr;
    logic [csb_pkg::DATA_W-1:0] pwdata;
    logic [csb_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [csb_pkg::PC_W-1:0] pc;
    logic [csb_pkg::FLAG_W-1:0] flags;
    logic busy;
    int errors;
    int checked;
    csb_row_t rows [25];

    csb_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pc(pc), .flags(flags), .busy(busy));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // holds the request until pready is seen high at a rising edge, no fixed latency assumed
    task automatic apb_rw(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_rw

    function automatic logic [7:0] cmp_flags(logic [7:0] fl, logic [7:0] rd, logic [7:0] k);
        logic [7:0] r;
        logic [7:0] f;
        r = rd - k;
        f = fl;
        f[csb_pkg::FLG_BORROW] = (k > rd);
        f[csb_pkg::FLG_NULL] = (r == 8'h00);
        f[csb_pkg::FLG_MSB] = r[7];
        f[csb_pkg::FLG_WRAP] = (rd[7] & ~k[7] & ~r[7]) | (~rd[7] & k[7] & r[7]);
        f[csb_pkg::FLG_NIBBLE] = (~rd[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~rd[3]);
        return f;
    endfunction : cmp_flags

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        // a hang is cut short well past the expected run of about 500 cycles
        repeat (8000) @(posedge pclk);
        errors++;
        test_done();
    end

    initial
    begin
        logic [31:0] q;
        logic e;
        logic [15:0] exp_pc;
        logic [7:0] exp_fl;
        logic [1:0] cyc;
        csb_row_t r;
        errors = 0;
        checked = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        // op, reg, imm/io, offset, bit, two-word, flags, pc, taken
        rows = '{'{4'h0, 8'h10, 8'h20, 7'h00, 3'h0, 1'b0, 8'h10, 16'h0040, 1'b0},
            '{4'h0, 8'h45, 8'h45, 7'h00, 3'h0, 1'b0, 8'hff, 16'h0041, 1'b0},
            '{4'h0, 8'h80, 8'h01, 7'h00, 3'h0, 1'b0, 8'h00, 16'hffff, 1'b0},
            '{4'h1, 8'hf7, 8'h00, 7'h00, 3'h3, 1'b0, 8'h5a, 16'h0100, 1'b1},
            '{4'h1, 8'h08, 8'h00, 7'h00, 3'h3, 1'b1, 8'h5a, 16'h0100, 1'b0},
            '{4'h2, 8'h80, 8'h00, 7'h00, 3'h7, 1'b1, 8'ha5, 16'h0200, 1'b1},
            '{4'h2, 8'h7f, 8'h00, 7'h00, 3'h7, 1'b0, 8'ha5, 16'h0200, 1'b0},
            '{4'h3, 8'h00, 8'hfe, 7'h00, 3'h0, 1'b1, 8'h3c, 16'h0300, 1'b1},
            '{4'h3, 8'h00, 8'h01, 7'h00, 3'h0, 1'b0, 8'h3c, 16'h0300, 1'b0},
            '{4'h4, 8'h00, 8'h20, 7'h00, 3'h5, 1'b0, 8'hc3, 16'h0400, 1'b1},
            '{4'h4, 8'h00, 8'hdf, 7'h00, 3'h5, 1'b1, 8'hc3, 16'h0400, 1'b0},
            '{4'h5, 8'h00, 8'h00, 7'h7f, 3'h5, 1'b0, 8'h20, 16'h0500, 1'b1},
            '{4'h5, 8'h00, 8'h00, 7'h7f, 3'h5, 1'b0, 8'hdf, 16'h0500, 1'b0},
            '{4'h6, 8'h00, 8'h00, 7'h3f, 3'h4, 1'b0, 8'hef, 16'h0600, 1'b1},
            '{4'h6, 8'h00, 8'h00, 7'h3f, 3'h4, 1'b0, 8'h10, 16'h0600, 1'b0},
            '{4'h7, 8'h00, 8'h00, 7'h40, 3'h0, 1'b0, 8'h02, 16'h0000, 1'b1},
            '{4'h7, 8'h00, 8'h00, 7'h40, 3'h0, 1'b0, 8'hfd, 16'h0000, 1'b0},
            '{4'h8, 8'h00, 8'h00, 7'h05, 3'h0, 1'b0, 8'hfd, 16'h0700, 1'b1},
            '{4'h8, 8'h00, 8'h00, 7'h05, 3'h0, 1'b0, 8'h02, 16'h0700, 1'b0},
            '{4'h9, 8'h00, 8'h00, 7'h7e, 3'h0, 1'b0, 8'h01, 16'h0800, 1'b1},
            '{4'h9, 8'h00, 8'h00, 7'h7e, 3'h0, 1'b0, 8'hfe, 16'h0800, 1'b0},
            '{4'ha, 8'h00, 8'h00, 7'h10, 3'h0, 1'b0, 8'hfe, 16'h0900, 1'b1},
            '{4'ha, 8'h00, 8'h00, 7'h10, 3'h0, 1'b0, 8'h01, 16'h0900, 1'b0},
            '{4'hb, 8'h00, 8'h00, 7'h01, 3'h0, 1'b0, 8'h00, 16'hfffe, 1'b1},
            '{4'hb, 8'h00, 8'h00, 7'h01, 3'h0, 1'b0, 8'hff, 16'h0a00, 1'b0}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({16'h0000, pc, flags}, 32'h0000_0000);
        check(busy, 1'b0);
        apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
        check(q, 32'h0000_0000);
        $display("test reset values done");

        for (int i = 0; i < 25; i++)
        begin
            r = rows[i];
            apb_rw(1'b1, csb_pkg::OFS_FLAGS, {24'h00_0000, r.fl}, q, e);
            apb_rw(1'b1, csb_pkg::OFS_PC, {16'h0000, r.pc0}, q, e);
            apb_rw(1'b1, csb_pkg::OFS_OPERAND, {5'h00, r.tw, r.bs, r.off, r.imm, r.rv}, q, e);
            apb_rw(1'b1, csb_pkg::OFS_COMMAND, {28'h000_0000, r.op}, q, e);
            exp_fl = (r.op == 4'h0) ? cmp_flags(r.fl, r.rv, r.imm) : r.fl;
            cyc = !r.tk ? 2'h1 : (r.op >= 4'h5 || !r.tw) ? 2'h2 : 2'h3;
            if (!r.tk)
                exp_pc = r.pc0 + 16'h0001;
            else if (r.op >= 4'h5)
                exp_pc = r.pc0 + {{9{r.off[6]}}, r.off} + 16'h0001;
            else
                exp_pc = r.pc0 + (r.tw ? 16'h0003 : 16'h0002);
            @(negedge pclk);
            check(flags, exp_fl);
            check(pc, exp_pc);
            check(pc, exp_pc);
            check(busy, cyc > 2'h1);
            @(negedge pclk);
            check(busy, cyc > 2'h2);
            while (busy !== 1'b0)
                @(negedge pclk);
            apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
            check(q[5:0], {cyc, r.tk, 3'h0});
        end
        $display("test table done");

        // unmapped address and the write-only command word
        apb_rw(1'b1, 12'h014, 32'hffff_ffff, q, e);
        check(e, 1'b1);
        apb_rw(1'b0, 12'h014, 32'h0000_0000, q, e);
        check({e, q}, {1'b1, 32'h0000_0000});
        apb_rw(1'b0, csb_pkg::OFS_COMMAND, 32'h0000_0000, q, e);
        check({e, q}, {1'b0, 32'h0000_0000});
        $display("test address map done");

        // an unknown op code leaves pc alone and raises a sticky flag that write-one clears
        apb_rw(1'b1, csb_pkg::OFS_PC, 32'h0000_1234, q, e);
        apb_rw(1'b1, csb_pkg::OFS_COMMAND, 32'h0000_000c, q, e);
        apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
        check(q[2:0], 3'h2);
        check(pc, 16'h1234);
        apb_rw(1'b1, csb_pkg::OFS_STATUS, 32'h0000_0003, q, e);
        apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
        check(q[2:0], 3'h0);
        $display("test bad op done");

        // a command that lands while a two-word skip still runs is dropped and flagged
        apb_rw(1'b1, csb_pkg::OFS_PC, 32'h0000_0200, q, e);
        apb_rw(1'b1, csb_pkg::OFS_OPERAND, 32'h0400_0000, q, e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= csb_pkg::OFS_COMMAND;
        pwdata <= 32'h0000_0001;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        // back-to-back setup so the second command commits while busy is still high
        penable <= 1'b0;
        pwdata <= 32'h0000_0005;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
        check(q[5:0], 6'h39);
        check(pc, 16'h0203);
        apb_rw(1'b1, csb_pkg::OFS_STATUS, 32'h0000_0001, q, e);
        apb_rw(1'b0, csb_pkg::OFS_STATUS, 32'h0000_0000, q, e);
        check(q[0], 1'b0);
        $display("test refused command done");

        // reset in mid-run clears pc and flags without a clock edge
        apb_rw(1'b1, csb_pkg::OFS_FLAGS, 32'h0000_00ff, q, e);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check({16'h0000, pc, flags}, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        $display("test second reset done");
        test_done();
    end

endmodule : tb_csb_unit
